// >>> core/limit_bank_defines.vh
// Command codes, reset values and timing counts of the limit and configuration bank
`ifndef LIMIT_BANK_DEFINES_VH
`define LIMIT_BANK_DEFINES_VH
`define C_SLEW 8'h27
`define C_FREQ 8'h33
`define C_INPUT_START_THRESHOLD 8'h35
`define C_INPUT_STOP_THRESHOLD 8'h36
`define C_GAIN 8'h38
`define C_OVF 8'h40
`define C_OV_ACT 8'h41
`define C_OVW 8'h42
`define C_UVW 8'h43
`define C_UVF 8'h44
`define C_UV_ACT 8'h45
`define C_OCF 8'h46
`define C_OC_ACT 8'h47
`define C_OCW 8'h4a
`define C_OTF 8'h4f
`define C_OT_ACT 8'h50
`define C_OTW 8'h51
`define C_UTF 8'h53
`define C_UT_ACT 8'h54
`define C_VIN_OVF 8'h55
`define C_VIN_OV_ACT 8'h56
`define C_VIN_UVW 8'h58
`define C_IIN_OCW 8'h5d
`define C_TON 8'h60
`define R_SLEW 16'haa00
`define R_FREQ 16'hfb52
`define R_INPUT_START_THRESHOLD 16'hcb40
`define R_INPUT_STOP_THRESHOLD 16'hcb00
`define R_GAIN 16'haa8f
`define R_OVF 16'h119a
`define R_OV_ACT 16'h00b8
`define R_OVW 16'h1133
`define R_UVW 16'h0ecd
`define R_UVF 16'h0e66
`define R_UV_ACT 16'h00b8
`define R_OCF 16'he2d0
`define R_OC_ACT 16'h0000
`define R_OCW 16'he230
`define R_OTF 16'heb20
`define R_OT_ACT 16'h00b8
`define R_OTW 16'heaa8
`define R_UTF 16'he580
`define R_UT_ACT 16'h00b8
`define R_VIN_OVF 16'hd3e0
`define R_VIN_OV_ACT 16'h0080
`define R_VIN_UVW 16'hcb26
`define R_IIN_OCW 16'hd280
`define R_TON 16'h8000
`define R_OUT_MODE_EXP 8'h14
`define FIX_FRAC 16
`define CLK_NS 25
`define TICK_NS 15625
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`endif

// >>> core/l11_to_fixed.v
// Linear-11 word to signed fixed point with FRAC fraction bits
`timescale 1ns/10ps
`default_nettype none
module l11_to_fixed #(
  parameter FRAC = 16,
  parameter OUT_W = 48
) (
  input wire [15:0] word,
  output wire signed [OUT_W-1:0] value
);
  localparam [5:0] FRAC_W = FRAC;
  wire signed [OUT_W-1:0] mant = {{(OUT_W-11){word[10]}}, word[10:0]};
  // Exponent -16..15 plus 16 gives a shift of 0..31, never negative
  wire [5:0] shift = {word[15], word[15:11]} + FRAC_W;
  assign value = mant <<< shift;
endmodule // l11_to_fixed
`default_nettype wire

// >>> core/pmbus_limit_config_bank.v
// Paged limit and configuration command bank with limit monitor, turn-on delay and slew ramp
//
// Contract
// - Setpoint moves toward a new target at the programmed slew rate, default 0xaa00.
// - Non-paged switching frequency held at 0x33, default 0xfb52.
// - Conversion may start only once input voltage reaches start threshold, default 0xcb40.
// - Conversion stops when input voltage falls to stop threshold, default 0xcb00.
// - Output above overvoltage fault level applies its action byte; warn default 0x1133.
// - Output below undervoltage fault level applies its action byte; warn default 0x0ecd.
// - Output current above overcurrent fault level applies its action byte, default 0x00.
// - Temperature above hot fault level applies its action byte; warn default 0xeaa8.
// - Temperature below cold fault level applies its action byte, default 0xb8.
// - Input above input overvoltage fault level applies its action byte, default 0x80.
// - Input undervoltage warn 0xcb26 and input overcurrent warn 0xd280 are held.
// - After an on request, wait the turn-on delay before enabling the rail.
// - Per-page current-sense gain held at 0x38, default 0xaa8f.
// - Output voltage words are unsigned mantissas scaled by two to the minus twelve.
`timescale 1ns/10ps
`default_nettype none
`include "limit_bank_defines.vh"
module pmbus_limit_config_bank #(
  parameter [15:0] TICK_CYCLES = `TICK_CYCLES
) (
  input wire clock,
  input wire sys_rst,
  input wire cmd_write,
  input wire cmd_read,
  input wire [7:0] cmd_code,
  input wire cmd_page,
  input wire [15:0] cmd_wdata,
  input wire [1:0] run_pin,
  input wire [1:0] operation_on,
  input wire clear_faults,
  input wire [15:0] vin_meas,
  input wire [15:0] iin_meas,
  input wire [31:0] vout_meas,
  input wire [31:0] iout_meas,
  input wire [31:0] temp_meas,
  input wire [31:0] vout_target,
  output reg [15:0] rdata,
  output reg rvalid,
  output reg cmd_error,
  output reg [1:0] rail_enable,
  output reg vin_ok,
  output reg [31:0] setpoint,
  output reg [15:0] switching_khz,
  output reg [9:0] fault_status,
  output reg [7:0] warn_status,
  output reg [2:0] input_status,
  output reg [15:0] fault_action,
  output reg [1:0] fault_event,
  output reg alert
);
  localparam [4:0] S_SLEW = 5'd0, S_FREQ = 5'd1, S_INPUT_START_THRESHOLD = 5'd2, S_INPUT_STOP_THRESHOLD = 5'd3,
    S_GAIN = 5'd4, S_OVF = 5'd5, S_OV_ACT = 5'd6, S_OVW = 5'd7, S_UVW = 5'd8,
    S_UVF = 5'd9, S_UV_ACT = 5'd10, S_OCF = 5'd11, S_OC_ACT = 5'd12, S_OCW = 5'd13,
    S_OTF = 5'd14, S_OT_ACT = 5'd15, S_OTW = 5'd16, S_UTF = 5'd17, S_UT_ACT = 5'd18,
    S_VIN_OVF = 5'd19, S_VIN_OV_ACT = 5'd20, S_VIN_UVW = 5'd21, S_IIN_OCW = 5'd22,
    S_TON = 5'd23;
  localparam [2:0] ST_OFF = 3'b001, ST_WAIT = 3'b010, ST_ON = 3'b100;

  // Decode gives {known, paged, byte wide, slot}
  function [7:0] decode;
    input [7:0] code;
    begin
      case (code)
        `C_SLEW: decode = {3'b110, S_SLEW};
        `C_FREQ: decode = {3'b100, S_FREQ};
        `C_INPUT_START_THRESHOLD: decode = {3'b100, S_INPUT_START_THRESHOLD};
        `C_INPUT_STOP_THRESHOLD: decode = {3'b100, S_INPUT_STOP_THRESHOLD};
        `C_GAIN: decode = {3'b110, S_GAIN};
        `C_OVF: decode = {3'b110, S_OVF};
        `C_OV_ACT: decode = {3'b111, S_OV_ACT};
        `C_OVW: decode = {3'b110, S_OVW};
        `C_UVW: decode = {3'b110, S_UVW};
        `C_UVF: decode = {3'b110, S_UVF};
        `C_UV_ACT: decode = {3'b111, S_UV_ACT};
        `C_OCF: decode = {3'b110, S_OCF};
        `C_OC_ACT: decode = {3'b111, S_OC_ACT};
        `C_OCW: decode = {3'b110, S_OCW};
        `C_OTF: decode = {3'b110, S_OTF};
        `C_OT_ACT: decode = {3'b111, S_OT_ACT};
        `C_OTW: decode = {3'b110, S_OTW};
        `C_UTF: decode = {3'b110, S_UTF};
        `C_UT_ACT: decode = {3'b111, S_UT_ACT};
        `C_VIN_OVF: decode = {3'b100, S_VIN_OVF};
        `C_VIN_OV_ACT: decode = {3'b101, S_VIN_OV_ACT};
        `C_VIN_UVW: decode = {3'b100, S_VIN_UVW};
        `C_IIN_OCW: decode = {3'b100, S_IIN_OCW};
        `C_TON: decode = {3'b110, S_TON};
        default: decode = 8'h00;
      endcase
    end
  endfunction

  function [15:0] reset_value;
    input [4:0] slot;
    begin
      case (slot)
        S_SLEW: reset_value = `R_SLEW;
        S_FREQ: reset_value = `R_FREQ;
        S_INPUT_START_THRESHOLD: reset_value = `R_INPUT_START_THRESHOLD;
        S_INPUT_STOP_THRESHOLD: reset_value = `R_INPUT_STOP_THRESHOLD;
        S_GAIN: reset_value = `R_GAIN;
        S_OVF: reset_value = `R_OVF;
        S_OV_ACT: reset_value = `R_OV_ACT;
        S_OVW: reset_value = `R_OVW;
        S_UVW: reset_value = `R_UVW;
        S_UVF: reset_value = `R_UVF;
        S_UV_ACT: reset_value = `R_UV_ACT;
        S_OCF: reset_value = `R_OCF;
        S_OC_ACT: reset_value = `R_OC_ACT;
        S_OCW: reset_value = `R_OCW;
        S_OTF: reset_value = `R_OTF;
        S_OT_ACT: reset_value = `R_OT_ACT;
        S_OTW: reset_value = `R_OTW;
        S_UTF: reset_value = `R_UTF;
        S_UT_ACT: reset_value = `R_UT_ACT;
        S_VIN_OVF: reset_value = `R_VIN_OVF;
        S_VIN_OV_ACT: reset_value = `R_VIN_OV_ACT;
        S_VIN_UVW: reset_value = `R_VIN_UVW;
        S_IIN_OCW: reset_value = `R_IIN_OCW;
        S_TON: reset_value = `R_TON;
        default: reset_value = 16'h0000;
      endcase
    end
  endfunction

  // Page 1 copies of non-paged slots exist but are never addressed
  reg [15:0] bank [0:63];
  integer i;
  wire [7:0] dec = decode(cmd_code);
  wire [5:0] cmd_addr = {dec[6] & cmd_page, dec[4:0]};

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < 64; i = i + 1) begin
        bank[i] <= reset_value(i[4:0]);
      end
    end else if (cmd_write && dec[7]) begin
      bank[cmd_addr] <= dec[5] ? {8'h00, cmd_wdata[7:0]} : cmd_wdata;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      rvalid <= cmd_read & dec[7];
      cmd_error <= (cmd_read | cmd_write) & ~dec[7];
      if (cmd_read) begin
        rdata <= dec[7] ? bank[cmd_addr] : 16'h0000;
      end
    end
  end

  // Run pins come from outside: three flops, change accepted when the last two agree
  reg [1:0] run_s1, run_s2, run_s3, run_sync;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_s1 <= 2'b00;
      run_s2 <= 2'b00;
      run_s3 <= 2'b00;
      run_sync <= 2'b00;
    end else begin
      run_s1 <= run_pin;
      run_s2 <= run_s1;
      run_s3 <= run_s2;
      run_sync <= (run_s2 & run_s3) | (run_sync & (run_s2 | run_s3));
    end
  end

  reg [15:0] tick_cnt;
  reg tick;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYCLES - 16'h0001);
      tick_cnt <= (tick_cnt == TICK_CYCLES - 16'h0001) ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  // One shared pair of converters walks all linear-11 checks in turn; a check
  // repeats every 20 cycles, which is far faster than any power-stage event.
  reg [4:0] scan_idx;
  reg [4:0] lim_slot;
  wire scan_pg = (scan_idx >= 5'd12) && (scan_idx <= 5'd18);
  wire scan_paged = (scan_idx >= 5'd5) && (scan_idx <= 5'd18);
  wire [4:0] item = scan_idx - (scan_pg ? 5'd12 : 5'd5);
  wire [15:0] iout_sel = scan_pg ? iout_meas[31:16] : iout_meas[15:0];
  wire [15:0] temp_sel = scan_pg ? temp_meas[31:16] : temp_meas[15:0];
  wire [15:0] sel_lim = bank[{scan_pg, lim_slot}];
  wire [15:0] sel_meas = (scan_idx <= 5'd3) ? vin_meas : (scan_idx == 5'd4) ? iin_meas :
    (item <= 5'd1) ? iout_sel : temp_sel;
  wire sel_gt = ~((scan_idx == 5'd0) | (scan_idx == 5'd3) | (scan_paged & (item == 5'd4)));
  wire signed [47:0] lim_fx;
  wire signed [47:0] meas_fx;
  wire res = sel_gt ? (meas_fx > lim_fx) : (meas_fx < lim_fx);

  always @* begin
    case (scan_idx)
      5'd0: lim_slot = S_INPUT_START_THRESHOLD;
      5'd1: lim_slot = S_INPUT_STOP_THRESHOLD;
      5'd2: lim_slot = S_VIN_OVF;
      5'd3: lim_slot = S_VIN_UVW;
      5'd4: lim_slot = S_IIN_OCW;
      5'd5, 5'd12: lim_slot = S_OCF;
      5'd6, 5'd13: lim_slot = S_OCW;
      5'd7, 5'd14: lim_slot = S_OTF;
      5'd8, 5'd15: lim_slot = S_OTW;
      5'd9, 5'd16: lim_slot = S_UTF;
      5'd10, 5'd17: lim_slot = S_TON;
      5'd11, 5'd18: lim_slot = S_SLEW;
      default: lim_slot = S_FREQ;
    endcase
  end

  l11_to_fixed #(.FRAC(`FIX_FRAC), .OUT_W(48)) lim_conv (
    .word(sel_lim),
    .value(lim_fx)
  );
  l11_to_fixed #(.FRAC(`FIX_FRAC), .OUT_W(48)) meas_conv (
    .word(sel_meas),
    .value(meas_fx)
  );

  // Delay in 1/64 ms ticks and slew step in output LSBs per tick
  reg [63:0] ton_ticks;
  reg [31:0] slew_step;
  reg below_on, above_off;
  wire [15:0] raw_step = lim_fx[25:10];
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scan_idx <= 5'd0;
      ton_ticks <= 64'h0;
      slew_step <= {2{16'h0001}};
      switching_khz <= 16'h0000;
      below_on <= 1'b1;
      above_off <= 1'b0;
    end else begin
      scan_idx <= (scan_idx == 5'd19) ? 5'd0 : scan_idx + 5'd1;
      if (scan_idx == 5'd0) begin
        below_on <= res;
      end
      if (scan_idx == 5'd1) begin
        above_off <= res;
      end
      if (scan_paged && item == 5'd5) begin
        ton_ticks[{scan_pg, 5'd0} +: 32] <= lim_fx[47] ? 32'h0 : lim_fx[41:10];
      end
      if (scan_paged && item == 5'd6) begin
        slew_step[{scan_pg, 4'd0} +: 16] <= (lim_fx[47] || raw_step == 16'h0000) ? 16'h0001 :
          (|lim_fx[41:26]) ? 16'hffff : raw_step;
      end
      if (scan_idx == 5'd19) begin
        switching_khz <= lim_fx[47] ? 16'h0000 : lim_fx[31:16];
      end
    end
  end

  // Fault bits per page: ov uv oc hot cold; warn bits per page: ov uv oc hot
  reg [9:0] fault_set;
  reg [7:0] warn_set;
  reg [2:0] in_set;
  reg [15:0] next_action;
  integer p;
  integer fb;
  integer wb;
  always @* begin
    fault_set = 10'h000;
    warn_set = 8'h00;
    in_set = 3'b000;
    fb = scan_pg ? 5 : 0;
    wb = scan_pg ? 4 : 0;
    for (p = 0; p < 2; p = p + 1) begin
      fault_set[p * 5] = vout_meas[p * 16 +: 16] > bank[{p[0], S_OVF}];
      fault_set[p * 5 + 1] = vout_meas[p * 16 +: 16] < bank[{p[0], S_UVF}];
      warn_set[p * 4] = vout_meas[p * 16 +: 16] > bank[{p[0], S_OVW}];
      warn_set[p * 4 + 1] = vout_meas[p * 16 +: 16] < bank[{p[0], S_UVW}];
    end
    if (scan_idx == 5'd2) begin
      in_set[0] = res;
    end
    if (scan_idx == 5'd3) begin
      in_set[1] = res;
    end
    if (scan_idx == 5'd4) begin
      in_set[2] = res;
    end
    if (scan_paged) begin
      case (item)
        5'd0: fault_set[fb + 2] = res;
        5'd1: warn_set[wb + 2] = res;
        5'd2: fault_set[fb + 3] = res;
        5'd3: warn_set[wb + 3] = res;
        5'd4: fault_set[fb + 4] = res;
        default: ;
      endcase
    end
    // Later assignments win, so output overvoltage has the highest priority
    next_action = fault_action;
    for (p = 0; p < 2; p = p + 1) begin
      if (in_set[0]) begin
        next_action[p * 8 +: 8] = bank[{1'b0, S_VIN_OV_ACT}][7:0];
      end
      if (fault_set[p * 5 + 4]) begin
        next_action[p * 8 +: 8] = bank[{p[0], S_UT_ACT}][7:0];
      end
      if (fault_set[p * 5 + 3]) begin
        next_action[p * 8 +: 8] = bank[{p[0], S_OT_ACT}][7:0];
      end
      if (fault_set[p * 5 + 2]) begin
        next_action[p * 8 +: 8] = bank[{p[0], S_OC_ACT}][7:0];
      end
      if (fault_set[p * 5 + 1]) begin
        next_action[p * 8 +: 8] = bank[{p[0], S_UV_ACT}][7:0];
      end
      if (fault_set[p * 5]) begin
        next_action[p * 8 +: 8] = bank[{p[0], S_OV_ACT}][7:0];
      end
    end
  end

  // A new detection in the clearing cycle survives the clear
  wire [9:0] next_fault = (fault_status & ~{10{clear_faults}}) | fault_set;
  wire [7:0] next_warn = (warn_status & ~{8{clear_faults}}) | warn_set;
  wire [2:0] next_input = (input_status & ~{3{clear_faults}}) | in_set;
  wire next_vin_ok = ~below_on | (vin_ok & above_off);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fault_status <= 10'h000;
      warn_status <= 8'h00;
      input_status <= 3'b000;
      fault_action <= 16'h0000;
      fault_event <= 2'b00;
      alert <= 1'b0;
      vin_ok <= 1'b0;
    end else begin
      fault_status <= next_fault;
      warn_status <= next_warn;
      input_status <= next_input;
      fault_action <= next_action;
      fault_event <= {|fault_set[9:5] | in_set[0], |fault_set[4:0] | in_set[0]};
      alert <= |{next_fault, next_warn, next_input};
      vin_ok <= next_vin_ok;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : rail
      reg [2:0] state;
      reg [31:0] delay_cnt;
      wire on_req = run_sync[g] & operation_on[g] & vin_ok;
      wire [15:0] cur = setpoint[g * 16 +: 16];
      wire [15:0] tgt = vout_target[g * 16 +: 16];
      wire [15:0] step = slew_step[g * 16 +: 16];
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          state <= ST_OFF;
          delay_cnt <= 32'h0;
          rail_enable[g] <= 1'b0;
        end else begin
          case (state)
            ST_OFF: begin
              if (on_req) begin
                state <= ST_WAIT;
                delay_cnt <= 32'h0;
              end
            end
            ST_WAIT: begin
              if (!on_req) begin
                state <= ST_OFF;
              end else if (delay_cnt >= ton_ticks[g * 32 +: 32]) begin
                state <= ST_ON;
                rail_enable[g] <= 1'b1;
              end else if (tick) begin
                delay_cnt <= delay_cnt + 32'h1;
              end
            end
            ST_ON: begin
              if (!on_req) begin
                state <= ST_OFF;
                rail_enable[g] <= 1'b0;
              end
            end
            default: begin
              state <= ST_OFF;
              rail_enable[g] <= 1'b0;
            end
          endcase
        end
      end
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          setpoint[g * 16 +: 16] <= 16'h0000;
        end else if (tick && cur < tgt) begin
          setpoint[g * 16 +: 16] <= (tgt - cur > step) ? cur + step : tgt;
        end else if (tick && cur > tgt) begin
          setpoint[g * 16 +: 16] <= (cur - tgt > step) ? cur - step : tgt;
        end
      end
    end
  endgenerate
endmodule // pmbus_limit_config_bank
`default_nettype wire

// >>> test/limit_bank_asserts.sv
// Port-level assertions for the limit and configuration bank
`timescale 1ns/10ps
`default_nettype none
module limit_bank_asserts #(
  parameter [15:0] TICK_CYCLES = 16'h0004
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_code,
  input wire logic [1:0] operation_on,
  input wire logic clear_faults,
  input wire logic [31:0] vout_target,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic cmd_error,
  input wire logic [1:0] rail_enable,
  input wire logic vin_ok,
  input wire logic [31:0] setpoint,
  input wire logic [9:0] fault_status,
  input wire logic [7:0] warn_status,
  input wire logic [2:0] input_status,
  input wire logic [15:0] fault_action,
  input wire logic [1:0] fault_event,
  input wire logic alert
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence stop_seen;
    $fell(vin_ok);
  endsequence
  sequence rails_off;
    ##[1:2] rail_enable == 2'b00;
  endsequence
  sequence ramp_step;
    setpoint[15:0] >= $past(setpoint[15:0]) && setpoint[15:0] <= $past(vout_target[15:0]);
  endsequence
  chk_unknown_read: assert property (cmd_read && cmd_code == 8'h00 |=> cmd_error && !rvalid && rdata == 16'h0000)
    else $error("unknown read not refused");
  chk_unknown_write: assert property (cmd_write && cmd_code == 8'h61 |=> cmd_error && !rvalid)
    else $error("unknown write not refused");
  chk_event_status: assert property (fault_event[0] |-> (|{fault_status[4:0], input_status[0]}))
    else $error("fault event without fault status");
  chk_action_cause: assert property ($changed(fault_action[7:0]) |-> fault_event[0])
    else $error("action byte changed without fault");
  chk_alert_or: assert property (alert == (|{fault_status, warn_status, input_status}))
    else $error("alert differs from status");
  chk_fault_sticky: assert property (fault_status[0] && !clear_faults |=> fault_status[0])
    else $error("fault status lost");
  chk_rail_start: assert property ($rose(rail_enable[0]) |-> vin_ok && $past(operation_on[0]))
    else $error("rail started without request");
  chk_rail_stop: assert property (stop_seen |-> rails_off)
    else $error("rail kept on below stop level");
  chk_slew_ramp: assert property ($stable(vout_target[15:0]) && setpoint[15:0] < vout_target[15:0] |=> ramp_step)
    else $error("setpoint ramp wrong");
endmodule // limit_bank_asserts
bind pmbus_limit_config_bank limit_bank_asserts #(.TICK_CYCLES(TICK_CYCLES)) limit_bank_asserts_i (
  .clock(clock), .sys_rst(sys_rst), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_code(cmd_code),
  .operation_on(operation_on), .clear_faults(clear_faults), .vout_target(vout_target), .rdata(rdata),
  .rvalid(rvalid), .cmd_error(cmd_error), .rail_enable(rail_enable), .vin_ok(vin_ok), .setpoint(setpoint),
  .fault_status(fault_status), .warn_status(warn_status), .input_status(input_status),
  .fault_action(fault_action), .fault_event(fault_event), .alert(alert));
`default_nettype wire

// >>> test/pmbus_host_model.sv
// Host side of the command port issuing one-cycle read and write requests
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model (
  input wire logic clock,
  output logic cmd_write,
  output logic cmd_read,
  output logic [7:0] cmd_code,
  output logic cmd_page,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic cmd_error
);
  initial begin
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    cmd_code = 8'h00;
    cmd_page = 1'b0;
    cmd_wdata = 16'h0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] c, input logic pg, input logic [15:0] d,
    output logic [15:0] q, output logic ok, output logic err);
    @(posedge clock);
    cmd_write <= wr;
    cmd_read <= !wr;
    cmd_code <= c;
    cmd_page <= pg;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_write <= 1'b0;
    cmd_read <= 1'b0;
    // Idle lines flip so a decode outside the strobe cannot reuse stale values
    cmd_code <= ~c;
    cmd_page <= ~pg;
    cmd_wdata <= ~d;
    #1;
    q = rdata;
    ok = rvalid;
    err = cmd_error;
  endtask
endmodule // pmbus_host_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the limit bank against a register model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int TK = 4;
  // Ramp of 0x800 LSBs at 0.25 V/ms, 2^-12 V per LSB, 64 ticks per ms
  localparam int RAMP = 16'h0800 / (512 * 4096 / 2048 / 64) * TK;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clear_faults = 1'b0;
  logic [1:0] run_pin = 2'b00, operation_on = 2'b00, rail_enable, fault_event;
  logic [15:0] vin_meas = 16'h000c, iin_meas = 16'h0000, rdata, switching_khz, fault_action;
  logic [31:0] vout_meas = {2{16'h1000}}, iout_meas = 32'h0, temp_meas = {2{16'h0019}}, vout_target = 32'h0;
  logic [31:0] setpoint;
  logic cmd_write, cmd_read, cmd_page, rvalid, cmd_error, vin_ok, alert;
  logic [7:0] cmd_code, warn_status;
  logic [15:0] cmd_wdata;
  logic [9:0] fault_status;
  logic [2:0] input_status;
  int err_total = 0, n_checks = 0;
  logic [15:0] model [0:511];
  logic [7:0] codes [0:23] = '{8'h27, 8'h33, 8'h35, 8'h36, 8'h38, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
    8'h46, 8'h47, 8'h4a, 8'h4f, 8'h50, 8'h51, 8'h53, 8'h54, 8'h55, 8'h56, 8'h58, 8'h5d, 8'h60};
  logic [15:0] resets [0:23] = '{16'haa00, 16'hfb52, 16'hcb40, 16'hcb00, 16'haa8f, 16'h119a, 16'h00b8,
    16'h1133, 16'h0ecd, 16'h0e66, 16'h00b8, 16'he2d0, 16'h0000, 16'he230, 16'heb20, 16'h00b8, 16'heaa8,
    16'he580, 16'h00b8, 16'hd3e0, 16'h0080, 16'hcb26, 16'hd280, 16'h8000};
  pmbus_limit_config_bank #(.TICK_CYCLES(16'(TK))) pmbus_limit_config_bank_i (.clock(clock), .sys_rst(sys_rst),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
    .run_pin(run_pin), .operation_on(operation_on), .clear_faults(clear_faults), .vin_meas(vin_meas),
    .iin_meas(iin_meas), .vout_meas(vout_meas), .iout_meas(iout_meas), .temp_meas(temp_meas),
    .vout_target(vout_target), .rdata(rdata), .rvalid(rvalid), .cmd_error(cmd_error), .rail_enable(rail_enable),
    .vin_ok(vin_ok), .setpoint(setpoint), .switching_khz(switching_khz), .fault_status(fault_status),
    .warn_status(warn_status), .input_status(input_status), .fault_action(fault_action),
    .fault_event(fault_event), .alert(alert));
  pmbus_host_model pmbus_host_model_i (.clock(clock), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rdata(rdata), .rvalid(rvalid),
    .cmd_error(cmd_error));
  function automatic int idx(input logic [7:0] c, input logic pg);
    return (c inside {8'h33, 8'h35, 8'h36, 8'h55, 8'h56, 8'h58, 8'h5d} ? 0 : int'(pg)) * 256 + int'(c);
  endfunction
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic pg);
    logic [15:0] q;
    logic ok, er;
    pmbus_host_model_i.xfer(1'b0, c, pg, 16'h0000, q, ok, er);
    check("rdata", model[idx(c, pg)], q);
    check("rvalid", 16'h0001, {15'h0, ok});
  endtask
  task automatic wr(input logic [7:0] c, input logic pg, input logic [15:0] d);
    logic [15:0] q;
    logic ok, er;
    pmbus_host_model_i.xfer(1'b1, c, pg, d, q, ok, er);
    model[idx(c, pg)] = (c inside {8'h41, 8'h45, 8'h47, 8'h50, 8'h54, 8'h56}) ? {8'h00, d[7:0]} : d;
    check("cmd_error", 16'h0000, {15'h0, er});
  endtask
  task automatic fc(input int s, input logic [31:0] v, input int b, input logic [7:0] a, input int pg);
    @(posedge clock);
    case (s)
      0: vout_meas <= v;
      1: iout_meas <= v;
      default: temp_meas <= v;
    endcase
    repeat (22) step();
    check("fault_bit", 16'h0001, {15'h0, fault_status[b]});
    check("fault_action", {8'h00, a}, {8'h00, fault_action[pg*8 +: 8]});
    @(posedge clock);
    vout_meas <= {2{16'h1000}};
    iout_meas <= 32'h0;
    temp_meas <= {2{16'h0019}};
    repeat (22) step();
    @(posedge clock);
    clear_faults <= 1'b1;
    @(posedge clock);
    clear_faults <= 1'b0;
    repeat (2) step();
    check("cleared", 16'h0000, {6'h0, fault_status} | {8'h0, warn_status});
  endtask
  initial begin
    forever #12.5 clock = ~clock;
  end
  initial begin
    #500000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] q;
    logic ok, er;
    int n;
    void'($urandom(32'ha923));
    for (int k = 0; k < 24; k++) for (int p = 0; p < 2; p++) model[idx(codes[k], p[0])] = resets[k];
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    for (int k = 0; k < 24; k++) for (int p = 0; p < 2; p++) rd(codes[k], p[0]);
    pmbus_host_model_i.xfer(1'b1, 8'h61, 1'b0, 16'h1234, q, ok, er);
    check("unknown_write", 16'h0001, {15'h0, er});
    pmbus_host_model_i.xfer(1'b0, 8'h00, 1'b0, 16'h0000, q, ok, er);
    check("unknown_read", 16'h0001, {15'h0, er});
    check("unknown_data", 16'h0000, q);
    check("switching_khz", 16'h01a9, switching_khz);
    for (n = 0; n < 30 && vin_ok !== 1'b1; n++) step();
    check("vin_ok", 16'h0001, {15'h0, vin_ok});
    @(posedge clock);
    run_pin <= 2'b01;
    operation_on <= 2'b01;
    for (n = 0; n < 12 && rail_enable[0] !== 1'b1; n++) step();
    check("rail_now", 16'h0001, {15'h0, rail_enable[0]});
    @(posedge clock);
    operation_on <= 2'b00;
    repeat (3) step();
    check("rail_off", 16'h0000, {14'h0, rail_enable});
    wr(8'h60, 1'b0, 16'h0001);
    // The delay word reaches the rail counter only once the scan has passed its slot
    repeat (22) step();
    @(posedge clock);
    operation_on <= 2'b01;
    for (n = 0; n < 64 * TK + 40 && rail_enable[0] !== 1'b1; n++) step();
    check("ton_wait", 16'h0001, {15'h0, n >= 64 * TK && n <= 64 * TK + 12});
    @(posedge clock);
    vout_target <= {16'h0000, 16'h0800};
    for (n = 0; n < 1000 && setpoint[15:0] !== 16'h0800; n++) step();
    check("ramp_time", 16'h0001, {15'h0, n >= RAMP - 8 && n <= RAMP + 8});
    @(posedge clock);
    vout_meas <= {16'h1000, 16'h1140};
    repeat (3) step();
    check("warn_only", 16'h0001, {15'h0, warn_status[0]});
    check("no_fault", 16'h0000, {6'h0, fault_status});
    check("alert", 16'h0001, {15'h0, alert});
    fc(0, {16'h1000, 16'h119b}, 0, 8'hb8, 0);
    fc(0, {16'h1000, 16'h0e00}, 1, 8'hb8, 0);
    wr(8'h47, 1'b1, 16'h125a);
    rd(8'h47, 1'b1);
    fc(1, {16'h0032, 16'h0000}, 7, 8'h5a, 1);
    fc(2, {16'h0019, 16'h0065}, 3, 8'hb8, 0);
    fc(2, {16'h07ce, 16'h0019}, 9, 8'hb8, 1);
    @(posedge clock);
    vin_meas <= 16'h0010;
    iin_meas <= 16'h000b;
    repeat (22) step();
    check("vin_ov", 16'h0001, {15'h0, input_status[0]});
    check("vin_ov_action", 16'h8080, fault_action);
    check("iin_oc_warn", 16'h0001, {15'h0, input_status[2]});
    @(posedge clock);
    vin_meas <= 16'h0006;
    repeat (22) step();
    check("vin_stop", 16'h0000, {15'h0, vin_ok});
    check("vin_uv_warn", 16'h0001, {15'h0, input_status[1]});
    check("rail_stop", 16'h0000, {14'h0, rail_enable});
    for (int k = 0; k < 24; k++) for (int p = 0; p < 2; p++) wr(codes[k], p[0], 16'($urandom()));
    for (int k = 0; k < 24; k++) for (int p = 0; p < 2; p++) rd(codes[k], p[0]);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
